/* timer_counter_pwm_unit_pkg.sv */
`default_nettype none

package timer_counter_pwm_unit_pkg;

   // ----------------------------------------------------------------
   // Bus and widths
   // ----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int TRIG_IN_W = 6;
   localparam int CTRL_W = 11;
   localparam int TRIG_W = 30;
   localparam int DT_W = 8;
   localparam int PRESC_W = 7;
   localparam int NUM_EVENTS = 6;
   localparam int EV_FIELD_W = 5;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TRIG = 8'h04;
   localparam logic [7:0] ADDR_CMP = 8'h08;
   localparam logic [7:0] ADDR_PER = 8'h0C;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   localparam logic [7:0] ADDR_CAPTURE = 8'h14;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
   localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
   localparam logic [7:0] ADDR_DEADTIME = 8'h20;
   localparam logic [7:0] ADDR_COMMAND = 8'h24;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_DIR_LSB = 4;
   localparam int CTRL_PRESC_LSB = 6;
   localparam int CTRL_SAFE_MAIN_BIT = 9;
   localparam int CTRL_SAFE_COMP_BIT = 10;
   localparam int INT_TC_BIT = 0;
   localparam int INT_CC_BIT = 1;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam int CMD_RELOAD_BIT = 2;
   localparam int CMD_CAPTURE_BIT = 3;
   localparam int EV_START = 0;
   localparam int EV_RELOAD = 1;
   localparam int EV_STOP = 2;
   localparam int EV_COUNT = 3;
   localparam int EV_CAPTURE = 4;
   localparam int EV_KILL = 5;
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_ONE = 3'h7;

   // ----------------------------------------------------------------
   // Reset values and LFSR taps
   // ----------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
   localparam logic [TRIG_W-1:0] TRIG_RESET = 30'h000F8000;
   localparam logic [31:0] CMP_RESET = 32'h00000000;
   localparam logic [31:0] PER_RESET = 32'hFFFFFFFF;
   localparam logic [DT_W-1:0] DEADTIME_RESET = 8'h04;
   localparam logic [31:0] LFSR_SEED = 32'h00000001;
   localparam logic [31:0] LFSR_TAPS = 32'h80200003;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_LEVEL} edge_t;
   typedef enum logic [2:0] {MODE_CMP, MODE_CAP, MODE_QUAD, MODE_PWM, MODE_PWM_PR,
                             MODE_PWM_DT} mode_t;
   typedef enum logic [1:0] {DIR_UP, DIR_DOWN, DIR_UPDOWN} dir_t;

endpackage

`default_nettype wire

/* event_detect.sv */
`default_nettype none

module event_detect (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Source and configuration
   input wire logic [timer_counter_pwm_unit_pkg::TRIG_IN_W-1:0] trigIn,
   input wire logic [timer_counter_pwm_unit_pkg::EV_FIELD_W-1:0] cfg,
   // Detected event
   output logic fire
);
   logic srcLevel;
   logic prevLevel;
   logic [2:0] srcSel;
   timer_counter_pwm_unit_pkg::edge_t edgeSel;

   assign srcSel = cfg[2:0];
   assign edgeSel = timer_counter_pwm_unit_pkg::edge_t'(cfg[4:3]);
   assign srcLevel = (srcSel == timer_counter_pwm_unit_pkg::SRC_NONE) ? 1'b0 :
                     (srcSel == timer_counter_pwm_unit_pkg::SRC_ONE) ? 1'b1 : trigIn[srcSel - 3'h1];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prevLevel <= 1'b0;
      end else begin
         prevLevel <= srcLevel;
      end
   end

   always_comb begin
      unique case (edgeSel)
         timer_counter_pwm_unit_pkg::EDGE_RISE: fire = srcLevel && !prevLevel;
         timer_counter_pwm_unit_pkg::EDGE_FALL: fire = !srcLevel && prevLevel;
         timer_counter_pwm_unit_pkg::EDGE_BOTH: fire = srcLevel ^ prevLevel;
         timer_counter_pwm_unit_pkg::EDGE_LEVEL: fire = srcLevel;
      endcase
   end
endmodule

`default_nettype wire

/* dead_time.sv */
`default_nettype none

module dead_time (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Raw level and gap length
   input wire logic rawIn,
   input wire logic [timer_counter_pwm_unit_pkg::DT_W-1:0] gapCycles,
   // Non-overlapping pair
   output logic outMain,
   output logic outComp
);
   logic lastRaw;
   logic [timer_counter_pwm_unit_pkg::DT_W-1:0] gapCnt;
   logic edgeSeen;
   logic inGap;

   assign edgeSeen = rawIn != lastRaw;
   assign inGap = edgeSeen || (gapCnt != '0);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lastRaw <= 1'b0;
         gapCnt <= '0;
      end else begin
         lastRaw <= rawIn;
         gapCnt <= edgeSeen ? gapCycles : (gapCnt != '0) ? gapCnt - 1'b1 : gapCnt;
      end
   end

   // Both lines rest low through the gap after each change.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         outMain <= 1'b0;
         outComp <= 1'b0;
      end else begin
         outMain <= !inGap && lastRaw;
         outComp <= !inGap && !lastRaw;
      end
   end
endmodule

`default_nettype wire

/* timer_counter_pwm_unit.sv */
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`default_nettype none

module timer_counter_pwm_unit #(
   parameter int COUNT_W = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // AHB-Lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Trigger and quadrature inputs
   input wire logic [timer_counter_pwm_unit_pkg::TRIG_IN_W-1:0] trigIn,
   input wire logic quadA,
   input wire logic quadB,
   // Channel outputs
   output logic pwmOut,
   output logic pwmOutN,
   output logic ovfOut,
   output logic unfOut,
   output logic ccOut,
   output logic irq
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [timer_counter_pwm_unit_pkg::CTRL_W-1:0] control;
   logic [timer_counter_pwm_unit_pkg::TRIG_W-1:0] trigCfg;
   logic [COUNT_W-1:0] cmpBuf;
   logic [COUNT_W-1:0] perBuf;
   logic [COUNT_W-1:0] cmpAct;
   logic [COUNT_W-1:0] perAct;
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] capture;
   logic [COUNT_W-1:0] next_count;
   logic [1:0] intStatus;
   logic [1:0] intMask;
   logic [1:0] intEvents;
   logic [timer_counter_pwm_unit_pkg::DT_W-1:0] deadTime;
   logic [timer_counter_pwm_unit_pkg::PRESC_W-1:0] prescCnt;
   logic [timer_counter_pwm_unit_pkg::PRESC_W-1:0] prescMask;
   logic [31:0] lfsr;
   logic [31:0] readData;
   logic [7:0] wrAddr;
   logic [3:0] cmdBits;
   logic [timer_counter_pwm_unit_pkg::NUM_EVENTS-1:0] evFire;
   logic [2:0] prescSel;
   timer_counter_pwm_unit_pkg::mode_t modeSel;
   timer_counter_pwm_unit_pkg::dir_t dirSel;
   logic addrPhase, wrPend, enable, runFlag, running, countDown, toggleLine;
   logic tick, quadMode, pwmMode, prMode, dtMode, capMode, bounce;
   logic prevA, prevB, quadStep, quadUp, stepEn, stepUp, atTop, atBottom;
   logic ovfHit, unfHit, tcEvent, ccHit, capFire, startEv, stopEv, reloadEv;
   logic killAct, safeMain, safeComp, pwmLevel, dtMain, dtComp, mainSel, compSel;
   logic [COUNT_W-1:0] pwmRef;

   function automatic logic writeTo(input logic pend, input logic [7:0] a,
                                    input logic [7:0] reg_addr);
      return pend && (a == reg_addr);
   endfunction

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addrPhase = hsel && hready && htrans[1];

   assign readData =
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_CTRL) ? 32'(control) :
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_TRIG) ? 32'(trigCfg) :
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_CMP) ? 32'(cmpBuf) :
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_PER) ? 32'(perBuf) :
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_COUNT) ? 32'(count) :
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_CAPTURE) ? 32'(capture) :
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_INT_STATUS) ? 32'(intStatus) :
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_INT_MASK) ? 32'(intMask) :
      (haddr[7:0] == timer_counter_pwm_unit_pkg::ADDR_DEADTIME) ? 32'(deadTime) : 32'h00000000;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         wrPend <= addrPhase && hwrite && (hsize == timer_counter_pwm_unit_pkg::HSIZE_WORD);
         wrAddr <= haddr[7:0];
         if (addrPhase && !hwrite) begin
            hrdata <= readData;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         control <= timer_counter_pwm_unit_pkg::CTRL_RESET;
         trigCfg <= timer_counter_pwm_unit_pkg::TRIG_RESET;
         cmpBuf <= timer_counter_pwm_unit_pkg::CMP_RESET[COUNT_W-1:0];
         perBuf <= timer_counter_pwm_unit_pkg::PER_RESET[COUNT_W-1:0];
         intMask <= 2'h0;
         deadTime <= timer_counter_pwm_unit_pkg::DEADTIME_RESET;
      end else begin
         if (writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_CTRL)) begin
            control <= hwdata[timer_counter_pwm_unit_pkg::CTRL_W-1:0];
         end
         if (writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_TRIG)) begin
            trigCfg <= hwdata[timer_counter_pwm_unit_pkg::TRIG_W-1:0];
         end
         if (writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_CMP)) begin
            cmpBuf <= hwdata[COUNT_W-1:0];
         end
         if (writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_PER)) begin
            perBuf <= hwdata[COUNT_W-1:0];
         end
         if (writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_INT_MASK)) begin
            intMask <= hwdata[1:0];
         end
         if (writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_DEADTIME)) begin
            deadTime <= hwdata[timer_counter_pwm_unit_pkg::DT_W-1:0];
         end
      end
   end

   assign cmdBits = writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_COMMAND) ? hwdata[3:0] : 4'h0;
   assign enable = control[timer_counter_pwm_unit_pkg::CTRL_ENABLE_BIT];
   assign modeSel = timer_counter_pwm_unit_pkg::mode_t'(control[timer_counter_pwm_unit_pkg::CTRL_MODE_LSB +: 3]);
   assign dirSel = timer_counter_pwm_unit_pkg::dir_t'(control[timer_counter_pwm_unit_pkg::CTRL_DIR_LSB +: 2]);
   assign prescSel = control[timer_counter_pwm_unit_pkg::CTRL_PRESC_LSB +: 3];
   assign safeMain = control[timer_counter_pwm_unit_pkg::CTRL_SAFE_MAIN_BIT];
   assign safeComp = control[timer_counter_pwm_unit_pkg::CTRL_SAFE_COMP_BIT];

   // Mode decode; codes 6 and 7 fall back to plain compare.
   always_comb begin
      {quadMode, pwmMode, prMode, dtMode, capMode} = 5'h00;
      unique case (modeSel)
         timer_counter_pwm_unit_pkg::MODE_CMP: capMode = 1'b0;
         timer_counter_pwm_unit_pkg::MODE_CAP: capMode = 1'b1;
         timer_counter_pwm_unit_pkg::MODE_QUAD: quadMode = 1'b1;
         timer_counter_pwm_unit_pkg::MODE_PWM: pwmMode = 1'b1;
         timer_counter_pwm_unit_pkg::MODE_PWM_PR: {pwmMode, prMode} = 2'h3;
         timer_counter_pwm_unit_pkg::MODE_PWM_DT: {pwmMode, dtMode} = 2'h3;
         default: capMode = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Event inputs
   // ----------------------------------------------------------------
   for (genvar g = 0; g < timer_counter_pwm_unit_pkg::NUM_EVENTS; g++) begin : gEvent
      event_detect uDetect (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .trigIn(trigIn),
         .cfg(trigCfg[g*timer_counter_pwm_unit_pkg::EV_FIELD_W +: timer_counter_pwm_unit_pkg::EV_FIELD_W]),
         .fire(evFire[g])
      );
   end

   assign startEv = evFire[timer_counter_pwm_unit_pkg::EV_START] || cmdBits[timer_counter_pwm_unit_pkg::CMD_START_BIT];
   assign stopEv = evFire[timer_counter_pwm_unit_pkg::EV_STOP] || cmdBits[timer_counter_pwm_unit_pkg::CMD_STOP_BIT];
   assign reloadEv = evFire[timer_counter_pwm_unit_pkg::EV_RELOAD] || cmdBits[timer_counter_pwm_unit_pkg::CMD_RELOAD_BIT];
   assign killAct = evFire[timer_counter_pwm_unit_pkg::EV_KILL];
   assign capFire = running && capMode &&
                    (evFire[timer_counter_pwm_unit_pkg::EV_CAPTURE] || cmdBits[timer_counter_pwm_unit_pkg::CMD_CAPTURE_BIT]);
   assign running = enable && runFlag;

   // ----------------------------------------------------------------
   // Prescaler, quadrature decode and LFSR
   // ----------------------------------------------------------------
   assign prescMask = (7'h01 << prescSel) - 7'h01;
   assign tick = (prescCnt & prescMask) == prescMask;
   assign quadStep = quadMode && ((quadA ^ prevA) ^ (quadB ^ prevB));
   assign quadUp = quadA ^ prevB;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prescCnt <= '0;
         prevA <= 1'b0;
         prevB <= 1'b0;
         lfsr <= timer_counter_pwm_unit_pkg::LFSR_SEED;
      end else begin
         prescCnt <= prescCnt + 1'b1;
         prevA <= quadA;
         prevB <= quadB;
         if (tick) begin
            lfsr <= lfsr[0] ? ((lfsr >> 1) ^ timer_counter_pwm_unit_pkg::LFSR_TAPS) : (lfsr >> 1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   assign bounce = (dirSel == timer_counter_pwm_unit_pkg::DIR_UPDOWN) && !quadMode;
   assign stepEn = running && (quadMode ? quadStep : tick && evFire[timer_counter_pwm_unit_pkg::EV_COUNT]);
   assign stepUp = quadMode ? quadUp : (dirSel == timer_counter_pwm_unit_pkg::DIR_DOWN) ? 1'b0 :
                   bounce ? !countDown : 1'b1;
   assign atTop = count == perAct;
   assign atBottom = count == '0;
   assign ovfHit = stepEn && stepUp && atTop;
   assign unfHit = stepEn && !stepUp && atBottom;
   assign tcEvent = ovfHit || unfHit;
   assign ccHit = stepEn && !capMode && !quadMode && (next_count == cmpAct);

   // Up/down turns round at the limits; the single-direction modes wrap.
   always_comb begin
      if (ovfHit) begin
         next_count = bounce ? count - 1'b1 : '0;
      end else if (unfHit) begin
         next_count = bounce ? count + 1'b1 : perAct;
      end else if (stepUp) begin
         next_count = count + 1'b1;
      end else begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
         runFlag <= 1'b0;
         countDown <= 1'b0;
      end else begin
         runFlag <= !stopEv && (runFlag || startEv || reloadEv);
         if (writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_COUNT)) begin
            count <= hwdata[COUNT_W-1:0];
         end else if (reloadEv && enable) begin
            count <= (dirSel == timer_counter_pwm_unit_pkg::DIR_DOWN) ? perAct : '0;
            countDown <= 1'b0;
         end else if (stepEn) begin
            count <= next_count;
            countDown <= bounce && (ovfHit || (countDown && !unfHit));
         end
      end
   end

   // Active values follow the pending copies while stopped.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cmpAct <= timer_counter_pwm_unit_pkg::CMP_RESET[COUNT_W-1:0];
         perAct <= timer_counter_pwm_unit_pkg::PER_RESET[COUNT_W-1:0];
      end else if (!running || tcEvent) begin
         cmpAct <= cmpBuf;
         perAct <= perBuf;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         capture <= '0;
      end else if (capFire) begin
         capture <= count;
      end
   end

   // ----------------------------------------------------------------
   // Event outputs and interrupts
   // ----------------------------------------------------------------
   assign intEvents = {ccHit || capFire, tcEvent};

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ovfOut <= 1'b0;
         unfOut <= 1'b0;
         ccOut <= 1'b0;
         intStatus <= 2'h0;
      end else begin
         ovfOut <= ovfHit;
         unfOut <= unfHit;
         ccOut <= ccHit || capFire;
         intStatus <= intEvents | (intStatus &
            ~(writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_INT_STATUS) ? hwdata[1:0] : 2'h0));
      end
   end

   assign irq = |(intStatus & intMask);

   // ----------------------------------------------------------------
   // Waveform outputs
   // ----------------------------------------------------------------
   assign pwmRef = prMode ? lfsr[COUNT_W-1:0] : count;
   assign pwmLevel = pwmRef < cmpAct;
   assign mainSel = !pwmMode ? toggleLine : dtMode ? dtMain : pwmLevel;
   assign compSel = dtMode ? dtComp : !mainSel;

   dead_time uDeadTime (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .rawIn(pwmLevel),
      .gapCycles(deadTime),
      .outMain(dtMain),
      .outComp(dtComp)
   );

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         toggleLine <= 1'b0;
         pwmOut <= 1'b0;
         pwmOutN <= 1'b1;
      end else begin
         toggleLine <= toggleLine ^ ccHit;
         pwmOut <= killAct ? safeMain : mainSel;
         pwmOutN <= killAct ? safeComp : compSel;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   AST_KILL_SAFE: assert property (
      killAct |=> (pwmOut == $past(safeMain)) && (pwmOutN == $past(safeComp)))
      else $error("Kill did not force the safe levels.");

   AST_COMPLEMENT: assert property (
      (pwmMode && !dtMode && !killAct) |=> (pwmOutN != pwmOut))
      else $error("Complementary output is not the inverse.");

   AST_DEAD_GAP: assert property (
      !(dtMain && dtComp))
      else $error("Dead-time pair overlaps.");

   AST_TC_FLAG: assert property (
      tcEvent |=> intStatus[timer_counter_pwm_unit_pkg::INT_TC_BIT] && (ovfOut || unfOut))
      else $error("Terminal count did not set its flag and event output.");

   AST_CAPTURE: assert property (
      capFire |=> (capture == $past(count)) && intStatus[timer_counter_pwm_unit_pkg::INT_CC_BIT] && ccOut)
      else $error("Capture did not latch the count.");

   AST_BUFFER_SWAP: assert property (
      (running && !tcEvent) ##1 running |-> $stable(perAct) && $stable(cmpAct))
      else $error("Active value changed outside terminal count.");

   AST_PRESCALE: assert property (
      ((prescSel == 3'h3) [*8] ##0 tick) |-> $past(tick, 8))
      else $error("Divide-by-eight tick spacing is wrong.");

   AST_UP_WRAP: assert property (
      (ovfHit && !bounce && !reloadEv && !writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_COUNT))
      |=> (count == '0) ##0 ovfOut)
      else $error("Up count did not wrap to zero at the period.");

   AST_QUAD_STEP: assert property (
      (quadStep && quadUp && running && !atTop && !reloadEv &&
       !writeTo(wrPend, wrAddr, timer_counter_pwm_unit_pkg::ADDR_COUNT)) |=> (count == $past(count) + 1'b1))
      else $error("Quadrature step did not count up by one.");

   AST_LFSR_PWM: assert property (
      (prMode && !killAct) |=> (pwmOut == ($past(lfsr[COUNT_W-1:0]) < $past(cmpAct))))
      else $error("Pseudo-random output does not follow the LFSR compare.");

   AST_IRQ_MASK: assert property (
      (ccHit && intMask[timer_counter_pwm_unit_pkg::INT_CC_BIT]) |=> irq)
      else $error("Unmasked compare match did not raise the interrupt.");

endmodule

`default_nettype wire

/* event_sink.sv */
`default_nettype none

module event_sink (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Control and event pulses
   input wire logic clr,
   input wire logic ovfOut,
   input wire logic unfOut,
   // Pulse counts
   output logic [7:0] ovfCnt,
   output logic [7:0] unfCnt
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Counts one-cycle event pulses like a downstream trigger sink.
   // ----------------------------------------------------------------
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst || clr) begin
         ovfCnt <= 8'h00;
         unfCnt <= 8'h00;
      end else begin
         ovfCnt <= ovfCnt + {7'h00, ovfOut};
         unfCnt <= unfCnt + {7'h00, unfOut};
      end
   end
endmodule

`default_nettype wire

/* timer_counter_pwm_unit_test.sv */
`default_nettype none

module timer_counter_pwm_unit_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic [5:0] trigIn = 6'h00;
   logic quadA = 1'b0;
   logic quadB = 1'b0;
   logic clr = 1'b0;
   wire hready;
   wire [31:0] hrdata;
   wire hresp, pwmOut, pwmOutN, ovfOut, unfOut, ccOut, irq;
   wire [7:0] ovfCnt, unfCnt;
   int error_cnt = 0;
   int check_count = 0;
   timer_counter_pwm_unit u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .trigIn(trigIn), .quadA(quadA), .quadB(quadB), .pwmOut(pwmOut), .pwmOutN(pwmOutN),
      .ovfOut(ovfOut), .unfOut(unfOut), .ccOut(ccOut), .irq(irq));
   event_sink u_sink (.clk_sys(clk_sys), .sys_rst(sys_rst), .clr(clr), .ovfOut(ovfOut),
      .unfOut(unfOut), .ovfCnt(ovfCnt), .unfCnt(unfCnt));
   always #25 clk_sys = ~clk_sys;
   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= timer_counter_pwm_unit_pkg::HSIZE_WORD;
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h00000000, r);
      chk("read", e, r);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk("pwmOutN", 32'h1, {31'h0, pwmOutN});
      rdc(timer_counter_pwm_unit_pkg::ADDR_TRIG, {2'h0, timer_counter_pwm_unit_pkg::TRIG_RESET});
      rdc(timer_counter_pwm_unit_pkg::ADDR_PER, timer_counter_pwm_unit_pkg::PER_RESET);
      rdc(timer_counter_pwm_unit_pkg::ADDR_DEADTIME, 32'h00000004);
      rdc(8'h28, 32'h00000000);
      $display("test reset done");
   endtask
   task automatic t_count();
      logic [1:0] d[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
      logic [2:0] p[4] = '{3'h0, 3'h0, 3'h0, 3'h1};
      logic [7:0] eo[4] = '{8'h06, 8'h00, 8'h04, 8'h03};
      logic [7:0] eu[4] = '{8'h00, 8'h06, 8'h04, 8'h00};
      wr(timer_counter_pwm_unit_pkg::ADDR_PER, 32'h00000003);
      wr(timer_counter_pwm_unit_pkg::ADDR_CMP, 32'h00000002);
      for (int i = 0; i < 4; i++) begin
         wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000002);
         wr(timer_counter_pwm_unit_pkg::ADDR_COUNT, 32'h00000000);
         wr(timer_counter_pwm_unit_pkg::ADDR_CTRL, {23'h000000, p[i], d[i], 3'h3, 1'b1});
         wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000001);
         repeat (10) @(posedge clk_sys);
         clr <= 1'b1;
         @(posedge clk_sys);
         clr <= 1'b0;
         repeat (24) @(posedge clk_sys);
         #1;
         chk("ovfCnt", {24'h0, eo[i]}, {24'h0, ovfCnt});
         chk("unfCnt", {24'h0, eu[i]}, {24'h0, unfCnt});
         chk("pwmOutN", {31'h0, ~pwmOut}, {31'h0, pwmOutN});
      end
      $display("test count done");
   endtask
   task automatic t_irq();
      wr(timer_counter_pwm_unit_pkg::ADDR_INT_MASK, 32'h00000001);
      repeat (3) @(posedge clk_sys);
      chk("irq", 32'h1, {31'h0, irq});
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000002);
      wr(timer_counter_pwm_unit_pkg::ADDR_INT_STATUS, 32'h00000003);
      wr(timer_counter_pwm_unit_pkg::ADDR_INT_MASK, 32'h00000000);
      rdc(timer_counter_pwm_unit_pkg::ADDR_INT_STATUS, 32'h00000000);
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000001);
      repeat (16) @(posedge clk_sys);
      chk("irq", 32'h0, {31'h0, irq});
      rdc(timer_counter_pwm_unit_pkg::ADDR_INT_STATUS, 32'h00000003);
      $display("test irq done");
   endtask
   task automatic t_modes();
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000002);
      wr(timer_counter_pwm_unit_pkg::ADDR_TRIG, 32'h00000000);
      wr(timer_counter_pwm_unit_pkg::ADDR_COUNT, 32'h00000002);
      wr(timer_counter_pwm_unit_pkg::ADDR_CTRL, 32'h00000003);
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000001);
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000008);
      rdc(timer_counter_pwm_unit_pkg::ADDR_CAPTURE, 32'h00000002);
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000002);
      wr(timer_counter_pwm_unit_pkg::ADDR_COUNT, 32'h00000000);
      wr(timer_counter_pwm_unit_pkg::ADDR_CTRL, 32'h00000005);
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000001);
      quadA <= 1'b1;
      repeat (2) @(posedge clk_sys);
      quadB <= 1'b1;
      repeat (2) @(posedge clk_sys);
      quadA <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rdc(timer_counter_pwm_unit_pkg::ADDR_COUNT, 32'h00000003);
      $display("test modes done");
   endtask
   task automatic t_kill();
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000002);
      wr(timer_counter_pwm_unit_pkg::ADDR_TRIG, 32'h320F8000);
      wr(timer_counter_pwm_unit_pkg::ADDR_CTRL, 32'h00000207);
      wr(timer_counter_pwm_unit_pkg::ADDR_COMMAND, 32'h00000001);
      @(posedge clk_sys);
      trigIn <= 6'h01;
      repeat (6) @(posedge clk_sys);
      chk("pwmOut", 32'h1, {31'h0, pwmOut});
      chk("pwmOutN", 32'h0, {31'h0, pwmOutN});
      trigIn <= 6'h00;
      $display("test kill done");
   endtask
   initial begin
      #(50 * 20000);
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_count();
      t_irq();
      t_modes();
      t_kill();
      print_verdict();
   end
endmodule

`default_nettype wire
